// >>> core/status_flag_irq_mask.sv
/*
  Sticky status flags with per-source interrupt masks, folded onto one
  active low interrupt output, plus the register port that reaches them.
  Assumes the live fault indicators come from logic on core_clk and that the
  master never raises read and write strobes together.
*/
`timescale 1ns/1ps
module status_flag_irq_mask #(
  parameter int ADDR_W = 12
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [irq_mask_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [irq_mask_pkg::DATA_W-1:0] reg_rdata,
  // live fault indicators
  input wire logic [irq_mask_pkg::NUM_IN-1:0] input_signal_absent,
  input wire logic [irq_mask_pkg::NUM_IN-1:0] input_frequency_offset,
  input wire logic pll_unlock,
  input wire logic retention_freerun,
  input wire logic pll_calibrating,
  input wire logic device_calibrating,
  input wire logic crystal_signal_absent,
  input wire logic reference_signal_absent,
  input wire logic crystal_lock_error,
  // interrupt
  output logic irq_out_n
);
  import irq_mask_pkg::*;

  typedef struct packed {
    logic [NUM_SRC-1:0] mask;
    logic [NUM_SRC-1:0] flag;
    logic [DATA_W-1:0] rdata;
    logic irq_n;
  } state_s;

  state_s st_reg;
  state_s st_next;
  logic [NUM_SRC-1:0] live;
  logic [NUM_SRC-1:0] wr_mask_hit;
  logic [NUM_SRC-1:0] wr_mask_val;
  logic [NUM_SRC-1:0] wr_clr_hit;
  logic [NUM_SRC-1:0] rd_mask_hit;
  logic [NUM_SRC-1:0] rd_flag_hit;
  logic [NUM_SRC-1:0] rd_live_hit;
  logic rd_any_hit;

  // source numbers of the single-bit indicators
  localparam int S_UNLOCK = 2 * NUM_IN;
  localparam int S_FREERUN = S_UNLOCK + 1;
  localparam int S_PLL_CAL = S_UNLOCK + 2;
  localparam int S_DEV_CAL = S_UNLOCK + 3;
  localparam int S_XTAL_ABSENT = S_UNLOCK + 4;
  localparam int S_REF_ABSENT = S_UNLOCK + 5;
  localparam int S_XTAL_LOCK = S_UNLOCK + 6;

  // byte addresses of the registers as the port sees them
  localparam logic [ADDR_W-1:0] A_DEV_LIVE = ADDR_W'(IDX_DEV_LIVE) << ADDR_SHIFT;
  localparam logic [ADDR_W-1:0] A_IN_MASK = ADDR_W'(IDX_IN_MASK) << ADDR_SHIFT;
  localparam logic [ADDR_W-1:0] A_PLL_MASK = ADDR_W'(IDX_PLL_MASK) << ADDR_SHIFT;
  localparam logic [ADDR_W-1:0] A_CAL_MASK = ADDR_W'(IDX_CAL_MASK) << ADDR_SHIFT;
  localparam logic [ADDR_W-1:0] A_DEV_MASK = ADDR_W'(IDX_DEV_MASK) << ADDR_SHIFT;

  if (ADDR_W < MIN_ADDR_W) begin : g_chk
    $error("ADDR_W too narrow for the register map");
  end

  if (NUM_SRC != 2 * NUM_IN + 7) begin : g_chk_src
    $error("NUM_SRC does not match the source list");
  end

  if (DATA_W < 8) begin : g_chk_data
    $error("DATA_W too narrow for the flag bit positions");
  end

  assign live = {crystal_lock_error, reference_signal_absent, crystal_signal_absent,
                 device_calibrating, pll_calibrating, retention_freerun, pll_unlock,
                 input_frequency_offset, input_signal_absent};

  assign rd_any_hit = |{rd_mask_hit, rd_flag_hit, rd_live_hit};

  // per-source address decode and bit placement
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
    localparam logic [ADDR_W-1:0] MASK_ADDR = ADDR_W'(SRC_MASK_IDX[i]) << ADDR_SHIFT;
    localparam logic [ADDR_W-1:0] FLAG_ADDR = ADDR_W'(SRC_FLAG_IDX[i]) << ADDR_SHIFT;
    localparam logic [ADDR_W-1:0] LIVE_ADDR = ADDR_W'(SRC_LIVE_IDX[i]) << ADDR_SHIFT;
    assign wr_mask_hit[i] = reg_write && (reg_addr == MASK_ADDR);
    assign wr_mask_val[i] = reg_wdata[SRC_BIT[i]];
    // only a 0 written to the flag bit asks for a clear
    assign wr_clr_hit[i] = reg_write && (reg_addr == FLAG_ADDR) && !reg_wdata[SRC_BIT[i]];
    assign rd_mask_hit[i] = reg_read && (reg_addr == MASK_ADDR);
    assign rd_flag_hit[i] = reg_read && (reg_addr == FLAG_ADDR);
    assign rd_live_hit[i] = reg_read && (reg_addr == LIVE_ADDR);
  end

  always_comb begin
    st_next = st_reg;
    st_next.mask = (st_reg.mask & ~wr_mask_hit) | (wr_mask_val & wr_mask_hit);
    // a live fault sets and also blocks the clear, so set always wins
    st_next.flag = live | (st_reg.flag & ~wr_clr_hit);
    // the output follows next state, so a mask write shows on the same edge
    st_next.irq_n = ~|(st_next.flag & ~st_next.mask);
    st_next.rdata = RDATA_IDLE;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (rd_mask_hit[i]) begin
        st_next.rdata[SRC_BIT[i]] = st_reg.mask[i];
      end
      if (rd_flag_hit[i]) begin
        st_next.rdata[SRC_BIT[i]] = st_reg.flag[i];
      end
      if (rd_live_hit[i]) begin
        st_next.rdata[SRC_BIT[i]] = live[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '{mask: MASK_RESET, flag: FLAG_RESET, rdata: RDATA_IDLE, irq_n: IRQ_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign irq_out_n = st_reg.irq_n;
  assign reg_rdata = st_reg.rdata;

  a_irq_on_flag: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ((st_reg.flag & ~st_reg.mask) != '0) |-> !irq_out_n)
    else $error("unmasked flag set but irq idle");

  a_irq_idle_masked: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ((st_reg.flag & ~st_reg.mask) == '0) |-> irq_out_n)
    else $error("irq active with no unmasked flag");

  a_irq_release: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $rose(irq_out_n) |-> ((($past(st_reg.flag) & ~st_reg.flag) != '0)
                          || (($past(st_reg.mask) ^ st_reg.mask) != '0)))
    else $error("irq released without a clear or mask change");

  a_clear_blocked: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ((wr_clr_hit & live) != '0) |=>
      ((st_reg.flag & $past(wr_clr_hit & live)) == $past(wr_clr_hit & live)))
    else $error("flag cleared while its fault is live");

  a_clear_honoured: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    ((wr_clr_hit & ~live) != '0) |=> ((st_reg.flag & $past(wr_clr_hit & ~live)) == '0))
    else $error("flag clear ignored with fault gone");

  a_flag_sticky: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (st_reg.flag != '0 && wr_clr_hit == '0) |=>
      ((st_reg.flag & $past(st_reg.flag)) == $past(st_reg.flag)))
    else $error("flag dropped without a clear");

  a_mask_reset: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_n) |-> (st_reg.mask == MASK_RESET))
    else $error("masks not zero out of reset");

  a_mask_write: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (wr_mask_hit != '0) |=>
      ((st_reg.mask & $past(wr_mask_hit)) == ($past(wr_mask_val) & $past(wr_mask_hit))))
    else $error("mask write not stored");

  a_mask_timely: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (wr_mask_hit != '0) |=> (st_reg.flag == $past(st_reg.flag | live))
      && (irq_out_n == ((st_reg.flag & ~st_reg.mask) == '0)))
    else $error("mask write disturbed flags or irq lagged");

  a_read_once: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !$past(reg_read) |-> (reg_rdata == RDATA_IDLE))
    else $error("read data outside the answer cycle");

  a_irq_cause: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $fell(irq_out_n) |->
      ((($past(live) & ~$past(st_reg.mask)) != '0) || (($past(st_reg.mask) & ~st_reg.mask) != '0)))
    else $error("irq raised with no fault and no unmask");

  a_reset_quiet: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    $rose(reset_n) |->
      (irq_out_n == IRQ_IDLE) && (st_reg.flag == FLAG_RESET) && (reg_rdata == RDATA_IDLE))
    else $error("state not idle out of reset");

  a_read_unmapped: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_read && !rd_any_hit) |=>
      (reg_rdata == RDATA_IDLE))
    else $error("unmapped read returned data");

  a_live_read_only: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && (reg_addr == A_DEV_LIVE)) |=>
      (st_reg.mask == $past(st_reg.mask)) && (st_reg.flag == ($past(st_reg.flag) | $past(live))))
    else $error("write to live register changed state");

  a_all_masked: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (st_reg.mask == '1) |->
      irq_out_n)
    else $error("irq active with every source ignored");

  // field-level mask storage, one per mask field
  a_absent_mask_field: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && (reg_addr == A_IN_MASK)) |=>
      (st_reg.mask[NUM_IN-1:0] == $past(reg_wdata[NUM_IN-1:0])))
    else $error("signal absent masks not stored");

  a_offset_mask_field: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && (reg_addr == A_IN_MASK)) |=>
      (st_reg.mask[2*NUM_IN-1:NUM_IN] == $past(reg_wdata[2*NUM_IN-1:NUM_IN])))
    else $error("frequency offset masks not stored");

  a_unlock_mask_bit: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && (reg_addr == A_PLL_MASK)) |=>
      (st_reg.mask[S_UNLOCK] == $past(reg_wdata[SRC_BIT[S_UNLOCK]])))
    else $error("unlock mask not stored");

  a_freerun_mask_bit: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && (reg_addr == A_PLL_MASK)) |=>
      (st_reg.mask[S_FREERUN] == $past(reg_wdata[SRC_BIT[S_FREERUN]])))
    else $error("freerun mask not stored");

  a_pll_cal_mask: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && (reg_addr == A_CAL_MASK)) |=>
      (st_reg.mask[S_PLL_CAL] == $past(reg_wdata[SRC_BIT[S_PLL_CAL]])))
    else $error("pll calibrating mask not stored");

  a_dev_cal_mask: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && (reg_addr == A_DEV_MASK)) |=>
      (st_reg.mask[S_DEV_CAL] == $past(reg_wdata[SRC_BIT[S_DEV_CAL]])))
    else $error("device calibrating mask not stored");

  a_xtal_absent_mask: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && (reg_addr == A_DEV_MASK)) |=>
      (st_reg.mask[S_XTAL_ABSENT] == $past(reg_wdata[SRC_BIT[S_XTAL_ABSENT]])))
    else $error("crystal absent mask not stored");

  a_ref_absent_mask: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && (reg_addr == A_DEV_MASK)) |=>
      (st_reg.mask[S_REF_ABSENT] == $past(reg_wdata[SRC_BIT[S_REF_ABSENT]])))
    else $error("reference absent mask not stored");

  a_xtal_lock_mask: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    (reg_write && (reg_addr == A_DEV_MASK)) |=>
      (st_reg.mask[S_XTAL_LOCK] == $past(reg_wdata[SRC_BIT[S_XTAL_LOCK]])))
    else $error("crystal lock error mask not stored");

  // per-source checks of set, clear, mask and readback
  for (genvar i = 0; i < NUM_SRC; i++) begin : g_src_chk
    localparam logic [NUM_SRC-1:0] ONE_HOT = NUM_SRC'(1) << i;
    localparam logic [ADDR_W-1:0] FLAG_A = ADDR_W'(SRC_FLAG_IDX[i]) << ADDR_SHIFT;

    a_src_sets: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      live[i] |=>
        st_reg.flag[i])
      else $error("fault did not set its flag");

    a_src_raises: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (live[i] && !st_reg.mask[i] && !wr_mask_hit[i]) |=>
        !irq_out_n)
      else $error("unmasked fault did not raise irq");

    a_src_ignored: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      ((st_reg.flag == ONE_HOT) && st_reg.mask[i]) |->
        irq_out_n)
      else $error("masked source raised irq");

    a_src_clear_held: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (wr_clr_hit[i] && live[i]) |=>
        st_reg.flag[i])
      else $error("flag cleared under live fault");

    a_src_clear_done: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (wr_clr_hit[i] && !live[i]) |=>
        !st_reg.flag[i])
      else $error("flag not cleared with fault gone");

    a_src_flag_kept: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (st_reg.flag[i] && !wr_clr_hit[i]) |=>
        st_reg.flag[i])
      else $error("flag dropped without a clear");

    a_src_no_spurious: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (!st_reg.flag[i] && !live[i]) |=>
        !st_reg.flag[i])
      else $error("flag set without a fault");

    a_src_write_one: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (reg_write && (reg_addr == FLAG_A) && reg_wdata[SRC_BIT[i]] && st_reg.flag[i]) |=>
        st_reg.flag[i])
      else $error("writing 1 cleared a flag");

    a_src_mask_store: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      wr_mask_hit[i] |=>
        (st_reg.mask[i] == $past(wr_mask_val[i])))
      else $error("mask bit not stored");

    a_src_mask_kept: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      !wr_mask_hit[i] |=>
        (st_reg.mask[i] == $past(st_reg.mask[i])))
      else $error("mask bit changed without a write");

    a_src_mask_flag: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (wr_mask_hit[i] && !live[i]) |=>
        (st_reg.flag[i] == $past(st_reg.flag[i])))
      else $error("mask write changed a flag");

    a_src_unmask_irq: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (st_reg.flag[i] && wr_mask_hit[i] && !wr_mask_val[i]) |=>
        !irq_out_n)
      else $error("unmask did not raise irq in time");

    a_src_mask_irq: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      (((st_reg.flag & ~ONE_HOT) == '0) && (live == '0) && wr_mask_hit[i] && wr_mask_val[i]) |=>
        irq_out_n)
      else $error("mask did not release irq in time");

    a_src_read_mask: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      rd_mask_hit[i] |=>
        (reg_rdata[SRC_BIT[i]] == $past(st_reg.mask[i])))
      else $error("mask readback wrong");

    a_src_read_flag: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      rd_flag_hit[i] |=>
        (reg_rdata[SRC_BIT[i]] == $past(st_reg.flag[i])))
      else $error("flag readback wrong");

    a_src_read_live: assert property (
      @(posedge core_clk) disable iff (!reset_n)
      rd_live_hit[i] |=>
        (reg_rdata[SRC_BIT[i]] == $past(live[i])))
      else $error("live readback wrong");
  end
endmodule : status_flag_irq_mask

// >>> core/irq_mask_pkg.sv
/*
  Constants for the sticky status flag and interrupt mask block: source
  numbering, register indices, bit positions and reset values.
  Assumes a register port whose byte address is four times a register index.
*/
package irq_mask_pkg;
  localparam int DATA_W = 8;
  localparam int NUM_IN = 4;
  localparam int NUM_SRC = 15;
  localparam int ADDR_SHIFT = 2;
  localparam int MIN_ADDR_W = 7;
  localparam logic IRQ_IDLE = 1'b1;
  localparam logic [NUM_SRC-1:0] MASK_RESET = 15'h0000;
  localparam logic [NUM_SRC-1:0] FLAG_RESET = 15'h0000;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 8'h00;
  // register indices
  localparam logic [7:0] IDX_DEV_LIVE = 8'h0c;
  localparam logic [7:0] IDX_IN_LIVE = 8'h0d;
  localparam logic [7:0] IDX_PLL_LIVE = 8'h0e;
  localparam logic [7:0] IDX_CAL_LIVE = 8'h0f;
  localparam logic [7:0] IDX_DEV_FLAG = 8'h11;
  localparam logic [7:0] IDX_IN_FLAG = 8'h12;
  localparam logic [7:0] IDX_PLL_FLAG = 8'h13;
  localparam logic [7:0] IDX_CAL_FLAG = 8'h14;
  localparam logic [7:0] IDX_DEV_MASK = 8'h17;
  localparam logic [7:0] IDX_IN_MASK = 8'h18;
  localparam logic [7:0] IDX_PLL_MASK = 8'h19;
  localparam logic [7:0] IDX_CAL_MASK = 8'h1a;
  // sources 0-3 signal absent, 4-7 frequency offset, 8 unlock, 9 freerun,
  // 10 pll calibrating, 11 device calibrating, 12 crystal absent,
  // 13 reference absent, 14 crystal lock error
  localparam logic [7:0] SRC_MASK_IDX [NUM_SRC] = '{
    IDX_IN_MASK, IDX_IN_MASK, IDX_IN_MASK, IDX_IN_MASK,
    IDX_IN_MASK, IDX_IN_MASK, IDX_IN_MASK, IDX_IN_MASK,
    IDX_PLL_MASK, IDX_PLL_MASK, IDX_CAL_MASK,
    IDX_DEV_MASK, IDX_DEV_MASK, IDX_DEV_MASK, IDX_DEV_MASK};
  localparam logic [7:0] SRC_FLAG_IDX [NUM_SRC] = '{
    IDX_IN_FLAG, IDX_IN_FLAG, IDX_IN_FLAG, IDX_IN_FLAG,
    IDX_IN_FLAG, IDX_IN_FLAG, IDX_IN_FLAG, IDX_IN_FLAG,
    IDX_PLL_FLAG, IDX_PLL_FLAG, IDX_CAL_FLAG,
    IDX_DEV_FLAG, IDX_DEV_FLAG, IDX_DEV_FLAG, IDX_DEV_FLAG};
  localparam logic [7:0] SRC_LIVE_IDX [NUM_SRC] = '{
    IDX_IN_LIVE, IDX_IN_LIVE, IDX_IN_LIVE, IDX_IN_LIVE,
    IDX_IN_LIVE, IDX_IN_LIVE, IDX_IN_LIVE, IDX_IN_LIVE,
    IDX_PLL_LIVE, IDX_PLL_LIVE, IDX_CAL_LIVE,
    IDX_DEV_LIVE, IDX_DEV_LIVE, IDX_DEV_LIVE, IDX_DEV_LIVE};
  localparam logic [2:0] SRC_BIT [NUM_SRC] = '{
    3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7,
    3'h1, 3'h5, 3'h5, 3'h0, 3'h1, 3'h2, 3'h3};
endpackage : irq_mask_pkg

// >>> test/host_bfm.sv
/*
  Host processor model: master of the register port.
  Assumes a slave that answers a read in the following cycle.
*/
`timescale 1ns/1ps
module host_bfm #(
  parameter int AW = 12
) (
  // clock
  input wire logic core_clk,
  // register port
  output logic [AW-1:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata
);
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= AW'({idx, 2'b00});
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    // released data no longer shows the written value
    reg_wdata <= ~d;
    #1;
  endtask : wr

  // a flag is cleared by writing 0 to it
  task automatic clr(input logic [7:0] idx);
    wr(idx, 8'h00);
  endtask : clr

  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= AW'({idx, 2'b00});
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : host_bfm

// >>> test/test_status_flag_irq_mask.sv
/*
  Self-checking bench for the sticky flag interrupt block.
  Assumes host_bfm drives the register port.
*/
`timescale 1ns/1ps
module test_status_flag_irq_mask;
  import irq_mask_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [NUM_SRC-1:0] live = '0;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_rdata;
  logic irq_out_n;
  int err_count = 0;
  int n_checks = 0;

  always #5 core_clk = ~core_clk;

  status_flag_irq_mask #(.ADDR_W(12)) u_status_flag_irq_mask (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .input_signal_absent(live[3:0]),
    .input_frequency_offset(live[7:4]), .pll_unlock(live[8]),
    .retention_freerun(live[9]), .pll_calibrating(live[10]),
    .device_calibrating(live[11]), .crystal_signal_absent(live[12]),
    .reference_signal_absent(live[13]), .crystal_lock_error(live[14]),
    .irq_out_n(irq_out_n));

  host_bfm #(.AW(12)) u_host_bfm (
    .core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic irq_is(input logic e);
    chk("irq_out_n", {7'h0, irq_out_n}, {7'h0, e});
  endtask : irq_is

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic t_reset();
    logic [7:0] d;
    irq_is(1'b1);
    for (int i = 0; i < 4; i++) begin
      u_host_bfm.rd(IDX_DEV_MASK + 8'(i), d);
      chk("mask reset", d, 8'h00);
    end
    u_host_bfm.wr(8'h1f, 8'hff);
    u_host_bfm.rd(8'h1f, d);
    chk("unmapped", d, 8'h00);
    u_host_bfm.rd(IDX_IN_MASK, d);
    chk("mask after unmapped write", d, 8'h00);
  endtask : t_reset

  task automatic t_source(input int s);
    logic [7:0] d;
    logic [7:0] b;
    b = 8'h01 << SRC_BIT[s];
    @(posedge core_clk);
    live[s] <= 1'b1;
    @(posedge core_clk);
    #1;
    irq_is(1'b0);
    u_host_bfm.rd(SRC_LIVE_IDX[s], d);
    chk("live shown", d & b, b);
    u_host_bfm.clr(SRC_FLAG_IDX[s]);
    u_host_bfm.rd(SRC_FLAG_IDX[s], d);
    chk("flag held", d & b, b);
    @(posedge core_clk);
    live[s] <= 1'b0;
    u_host_bfm.wr(SRC_MASK_IDX[s], b);
    irq_is(1'b1);
    u_host_bfm.rd(SRC_FLAG_IDX[s], d);
    chk("flag kept", d & b, b);
    u_host_bfm.wr(SRC_MASK_IDX[s], 8'h00);
    irq_is(1'b0);
    u_host_bfm.clr(SRC_FLAG_IDX[s]);
    irq_is(1'b1);
    u_host_bfm.rd(SRC_FLAG_IDX[s], d);
    chk("flag cleared", d & b, 8'h00);
  endtask : t_source

  // two causes: the pin stays low until both are cleared
  task automatic t_two();
    @(posedge core_clk);
    live <= 15'h0101;
    @(posedge core_clk);
    live <= '0;
    u_host_bfm.clr(IDX_IN_FLAG);
    irq_is(1'b0);
    u_host_bfm.clr(IDX_PLL_FLAG);
    irq_is(1'b1);
  endtask : t_two

  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    t_reset();
    for (int s = 0; s < NUM_SRC; s++) t_source(s);
    t_two();
    report_and_stop();
  end

  initial begin
    #100000;
    err_count++;
    report_and_stop();
  end
endmodule : test_status_flag_irq_mask
